/* File: rtl/pfci_pkg.sv */
// shared constants and types for the parallel flash command controller
package pfci_pkg;
	// word address and data widths of the flash
	localparam int AW = 22;
	localparam int DW = 16;
	localparam int CLK_NS = 10;
	// apb register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_CFG = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RDATA = 8'h14;
	// status and config field positions
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_TMO = 2;
	localparam int ST_SUSP = 3;
	localparam int ST_REJ = 4;
	localparam int ST_BAD = 5;
	localparam int CFG_PROT = 0;
	localparam logic CFG_PROT_RST = 1'b1;
	// status bit positions on the flash data bus
	localparam int POLL_POS = 7;
	localparam int TOGGLE_POS = 6;
	localparam int SUSP_TOG_POS = 2;
	// command codes and unlock addresses
	localparam logic [DW-1:0] CMD_UNL1 = 16'h00aa;
	localparam logic [DW-1:0] CMD_UNL2 = 16'h0055;
	localparam logic [DW-1:0] CMD_PROG = 16'h00a0;
	localparam logic [DW-1:0] CMD_ERASE = 16'h0080;
	localparam logic [DW-1:0] CMD_SECT = 16'h0030;
	localparam logic [DW-1:0] CMD_BLK = 16'h0050;
	localparam logic [DW-1:0] CMD_SUSP = 16'h00b0;
	localparam logic [DW-1:0] CMD_RESUME = 16'h0030;
	localparam logic [AW-1:0] UNL_ADDR1 = 22'h005555;
	localparam logic [AW-1:0] UNL_ADDR2 = 22'h002aaa;
	// erase granularity: 2 KWord sectors, 32 KWord blocks
	localparam int SECT_LSB = 11;
	localparam int BLK_LSB = 15;
	localparam logic [AW-BLK_LSB-1:0] PROT_BLK = 7'h00;
	// pin timing in ns and derived cycle counts (least times round up)
	localparam int T_WP_NS = 40;
	localparam int T_ACC_NS = 90;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	// operation times in us; longest times round down
	localparam int T_PROG_US = 10;
	localparam int T_SUSP_US = 20;
	localparam int PROG_MAX_CYC = T_PROG_US * 1000 / CLK_NS;
	localparam int SUSP_CYC = T_SUSP_US * 1000 / CLK_NS;
	typedef enum logic [2:0] {
		OP_NONE, OP_READ, OP_PROG, OP_SECT, OP_BLK, OP_SUSP, OP_RESUME
	} pfci_op_e;
endpackage

/* File: rtl/pfci_cyc_if.sv */
// single flash bus cycle request and answer between sequencer and pin engine
`timescale 1ns/1ps
interface pfci_cyc_if import pfci_pkg::*; ();
	logic req;
	logic wr;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic ack;
	logic [DW-1:0] rdata;
	modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
	modport engine (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

/* File: rtl/pfci_bus_cycle.sv */
// pin engine: runs one write or read cycle on the flash pins
`timescale 1ns/1ps
module pfci_bus_cycle import pfci_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	pfci_cyc_if.engine cy,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [AW-1:0] fl_addr,
	output logic [DW-1:0] dq_out,
	output logic dq_oe,
	input wire logic [DW-1:0] dq_in
);
	typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} pfci_cy_e;
	pfci_cy_e state;
	logic wr_q;
	logic [7:0] cnt;
	localparam logic [7:0] WP_LAST = 8'(WP_CYC - 1);
	localparam logic [7:0] ACC_LAST = 8'(ACC_CYC - 1);

	// chip select falls first, strobe later, so address is stable before it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= CY_IDLE;
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			fl_addr <= '0;
			dq_out <= '0;
			dq_oe <= 1'b0;
			wr_q <= 1'b0;
			cnt <= '0;
			cy.ack <= 1'b0;
			cy.rdata <= '0;
		end else begin
			cy.ack <= 1'b0;
			case (state)
				CY_IDLE: begin
					if (cy.req) begin
						fl_addr <= cy.addr;
						dq_out <= cy.wdata;
						wr_q <= cy.wr;
						dq_oe <= cy.wr; // never drive while a read may enable outputs
						ce_n <= 1'b0;
						state <= CY_SETUP;
					end
				end
				CY_SETUP: begin
					if (wr_q) begin
						we_n <= 1'b0; // strobe low while select held low
					end else begin
						oe_n <= 1'b0;
					end
					cnt <= '0;
					state <= CY_STROBE;
				end
				CY_STROBE: begin
					cnt <= cnt + 8'h01;
					if ((wr_q && cnt == WP_LAST) || (!wr_q && cnt == ACC_LAST)) begin
						if (!wr_q) begin
							cy.rdata <= dq_in;
						end
						// strobe rises before select, data still driven
						we_n <= 1'b1;
						oe_n <= 1'b1;
						state <= CY_HOLD;
					end
				end
				CY_HOLD: begin
					ce_n <= 1'b1; // deselect between cycles
					dq_oe <= 1'b0;
					cy.ack <= 1'b1;
					state <= CY_IDLE;
				end
				default: state <= CY_IDLE;
			endcase
		end
	end
endmodule

/* File: rtl/pfci_host.sv */
// apb-controlled host sequencer driving a parallel nor flash through its pins
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module pfci_host import pfci_pkg::*; #(
	parameter int ERASE_MAX_CYC = 10000000
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [AW-1:0] fl_addr,
	output logic [DW-1:0] dq_out,
	output logic dq_oe,
	input wire logic [DW-1:0] dq_in,
	output logic protect_n
);
	typedef enum logic [3:0] {
		SQ_IDLE, SQ_ISSUE, SQ_WAIT, SQ_POLL1, SQ_PW1, SQ_POLL2, SQ_PW2, SQ_SUSP
	} pfci_sq_e;

	pfci_cyc_if cy ();
	pfci_bus_cycle u_cyc (
		.clk_sys(clk_sys),
		.rst(rst),
		.cy(cy),
		.ce_n(ce_n),
		.we_n(we_n),
		.oe_n(oe_n),
		.fl_addr(fl_addr),
		.dq_out(dq_out),
		.dq_oe(dq_oe),
		.dq_in(dq_in)
	);

	pfci_sq_e state;
	pfci_op_e op_cur;
	logic [AW-1:0] tgt_addr;
	logic [DW-1:0] tgt_data;
	logic [DW-1:0] rdata;
	logic prot_cfg;
	logic [2:0] step;
	logic [31:0] timer;
	logic [31:0] limit;
	logic tog_prev;
	logic st_done, st_tmo, st_rej, st_bad, st_susp;
	logic susp_req;
	logic [AW-1:0] susp_addr;
	logic susp_blk;
	logic apb_acc, wr_ctrl, wr_stat, start, finish;
	pfci_op_e wr_op;
	logic in_susp_region, prot_hit, busy_erase;

	// fixed command sequences; unlock cycles are always exact
	function automatic logic [2:0] seq_last(input pfci_op_e op);
		case (op)
			OP_PROG: seq_last = 3'd3;
			OP_SECT, OP_BLK: seq_last = 3'd5;
			default: seq_last = 3'd0;
		endcase
	endfunction
	function automatic logic [AW-1:0] step_addr(input logic [2:0] k, input logic [AW-1:0] a);
		case (k)
			3'd0, 3'd2, 3'd3: step_addr = UNL_ADDR1;
			3'd1, 3'd4: step_addr = UNL_ADDR2;
			default: step_addr = a;
		endcase
	endfunction
	function automatic logic [DW-1:0] step_data(input pfci_op_e op, input logic [2:0] k,
			input logic [DW-1:0] d);
		step_data = d;
		case (op)
			OP_PROG: begin
				case (k)
					3'd0: step_data = CMD_UNL1;
					3'd1: step_data = CMD_UNL2;
					3'd2: step_data = CMD_PROG;
					default: step_data = d;
				endcase
			end
			OP_SECT, OP_BLK: begin
				case (k)
					3'd0, 3'd3: step_data = CMD_UNL1;
					3'd1, 3'd4: step_data = CMD_UNL2;
					3'd2: step_data = CMD_ERASE;
					default: step_data = (op == OP_SECT) ? CMD_SECT : CMD_BLK;
				endcase
			end
			OP_SUSP: step_data = CMD_SUSP;
			OP_RESUME: step_data = CMD_RESUME;
			default: step_data = d;
		endcase
	endfunction

	// apb decode; slave answers in the first access cycle
	assign apb_acc = psel & penable & pready;
	assign wr_ctrl = apb_acc & pwrite & (paddr == OFS_CTRL);
	assign wr_stat = apb_acc & pwrite & (paddr == OFS_STATUS);
	assign wr_op = pfci_op_e'(pwdata[2:0]);
	// region checks at sector or block granularity
	assign in_susp_region = susp_blk ?
		(tgt_addr[AW-1:BLK_LSB] == susp_addr[AW-1:BLK_LSB]) :
		(tgt_addr[AW-1:SECT_LSB] == susp_addr[AW-1:SECT_LSB]);
	assign prot_hit = !prot_cfg && (tgt_addr[AW-1:BLK_LSB] == PROT_BLK);
	assign busy_erase = (state != SQ_IDLE) && (op_cur == OP_SECT || op_cur == OP_BLK);
	// refusal rules: no command while busy except suspend during an erase, none that the flash would ignore
	always_comb begin
		start = 1'b0;
		if (wr_ctrl && state == SQ_IDLE) begin
			case (wr_op)
				OP_READ: start = 1'b1;
				OP_PROG: start = !(st_susp && in_susp_region);
				OP_SECT, OP_BLK: start = !st_susp && !prot_hit;
				OP_RESUME: start = st_susp;
				default: start = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable) begin
				case (paddr)
					OFS_CTRL: prdata <= {29'h0, op_cur};
					OFS_ADDR: prdata <= {10'h0, tgt_addr};
					OFS_WDATA: prdata <= {16'h0, tgt_data};
					OFS_CFG: prdata <= {31'h0, prot_cfg};
					OFS_STATUS: prdata <= {26'h0, st_bad, st_rej, st_susp, st_tmo, st_done,
						state != SQ_IDLE};
					OFS_RDATA: prdata <= {16'h0, rdata};
					default: pslverr <= 1'b1; // unmapped
				endcase
			end
		end
	end

	// parameter registers; only changed while idle so protect stays steady
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tgt_addr <= '0;
			tgt_data <= '0;
			prot_cfg <= CFG_PROT_RST;
			protect_n <= CFG_PROT_RST;
		end else begin
			if (apb_acc && pwrite && state == SQ_IDLE) begin
				if (paddr == OFS_ADDR) tgt_addr <= pwdata[AW-1:0];
				if (paddr == OFS_WDATA) tgt_data <= pwdata[DW-1:0];
				if (paddr == OFS_CFG) prot_cfg <= pwdata[CFG_PROT];
			end
			if (state == SQ_IDLE) begin
				protect_n <= prot_cfg;
			end
		end
	end

	// sticky flags: hardware set wins over write-one-to-clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_done <= 1'b0;
			st_rej <= 1'b0;
		end else begin
			st_done <= finish | (st_done & ~(wr_stat & pwdata[ST_DONE]));
			st_rej <= (wr_ctrl & ~start & ~(wr_op == OP_SUSP && busy_erase))
				| (st_rej & ~(wr_stat & pwdata[ST_REJ]));
		end
	end

	// main sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= SQ_IDLE;
			op_cur <= OP_NONE;
			step <= '0;
			timer <= '0;
			limit <= '0;
			tog_prev <= 1'b0;
			rdata <= '0;
			st_tmo <= 1'b0;
			st_bad <= 1'b0;
			st_susp <= 1'b0;
			susp_req <= 1'b0;
			susp_addr <= '0;
			susp_blk <= 1'b0;
			finish <= 1'b0;
			cy.req <= 1'b0;
			cy.wr <= 1'b0;
			cy.addr <= '0;
			cy.wdata <= '0;
		end else begin
			cy.req <= 1'b0;
			finish <= 1'b0;
			if (wr_stat && pwdata[ST_TMO]) st_tmo <= 1'b0;
			if (wr_stat && pwdata[ST_BAD]) st_bad <= 1'b0;
			// the only command taken mid-erase is suspend
			if (wr_ctrl && wr_op == OP_SUSP && busy_erase) susp_req <= 1'b1;
			if (state != SQ_IDLE) timer <= timer + 32'd1;
			case (state)
				SQ_IDLE: begin
					// a suspend that arrived as the erase ended must not hit a later erase
					susp_req <= 1'b0;
					if (start) begin
						op_cur <= wr_op;
						step <= '0;
						state <= SQ_ISSUE;
					end
				end
				SQ_ISSUE: begin
					cy.req <= 1'b1;
					cy.wr <= (op_cur != OP_READ);
					// last cycle of every sequence carries the target word address
					cy.addr <= (step == seq_last(op_cur)) ? tgt_addr : step_addr(step, tgt_addr);
					cy.wdata <= step_data(op_cur, step, tgt_data);
					state <= SQ_WAIT;
				end
				SQ_WAIT: begin
					if (cy.ack) begin
						if (op_cur == OP_READ) begin
							rdata <= cy.rdata; // inside a suspended region this is status
							finish <= 1'b1;
							state <= SQ_IDLE;
						end else if (step != seq_last(op_cur)) begin
							step <= step + 3'd1;
							state <= SQ_ISSUE;
						end else begin
							// internal operation now runs; poll it, except a suspend, which waits out its latency
							timer <= '0;
							case (op_cur)
								OP_PROG: begin
									limit <= 32'(PROG_MAX_CYC);
									state <= SQ_POLL1;
								end
								OP_SUSP: state <= SQ_SUSP;
								OP_RESUME: begin
									st_susp <= 1'b0;
									op_cur <= susp_blk ? OP_BLK : OP_SECT;
									limit <= 32'(ERASE_MAX_CYC);
									state <= SQ_POLL1;
								end
								default: begin
									susp_addr <= tgt_addr;
									susp_blk <= (op_cur == OP_BLK);
									limit <= 32'(ERASE_MAX_CYC);
									state <= SQ_POLL1;
								end
							endcase
						end
					end
				end
				SQ_POLL1: begin
					// no other command is written while polling
					if (susp_req) begin
						susp_req <= 1'b0;
						op_cur <= OP_SUSP;
						step <= '0;
						state <= SQ_ISSUE;
					end else if (timer >= limit) begin
						st_tmo <= 1'b1;
						finish <= 1'b1;
						state <= SQ_IDLE;
					end else begin
						cy.req <= 1'b1; // reads here are status only
						cy.wr <= 1'b0;
						cy.addr <= tgt_addr;
						state <= SQ_PW1;
					end
				end
				SQ_PW1: begin
					if (cy.ack) begin
						tog_prev <= cy.rdata[TOGGLE_POS];
						state <= SQ_POLL2;
					end
				end
				SQ_POLL2: begin
					cy.req <= 1'b1;
					cy.wr <= 1'b0;
					cy.addr <= tgt_addr;
					state <= SQ_PW2;
				end
				SQ_PW2: begin
					if (cy.ack) begin
						if (cy.rdata[TOGGLE_POS] != tog_prev) begin
							state <= SQ_POLL1; // still busy
						end else begin
							rdata <= cy.rdata;
							// finished program must read back the true bit
							if (op_cur == OP_PROG && cy.rdata[POLL_POS] != tgt_data[POLL_POS]) begin
								st_bad <= 1'b1;
							end
							finish <= 1'b1;
							state <= SQ_IDLE;
						end
					end
				end
				SQ_SUSP: begin
					// wait the suspend latency before reads are trusted
					if (timer >= 32'(SUSP_CYC)) begin
						st_susp <= 1'b1;
						finish <= 1'b1;
						state <= SQ_IDLE;
					end
				end
				default: state <= SQ_IDLE;
			endcase
		end
	end
endmodule

/* File: tb/pfci_flash_model.sv */
// behavioural flash device answering the host controller pins
`timescale 1ns/1ps
module pfci_flash_model import pfci_pkg::*; #(
	parameter int P_CYC = 300,
	parameter int E_CYC = 3000
) (
	input wire logic clk_sys,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [AW-1:0] fl_addr,
	input wire logic [DW-1:0] dq_out,
	input wire logic protect_n,
	output logic [DW-1:0] q
);
	logic [DW-1:0] mem [logic [AW-1:0]];
	logic [AW-1:0] la = '0, ea = '0;
	logic [DW-1:0] pd = '0, w, r = '0;
	logic pwe = 1'b1, poe = 1'b1, susp = 1'b0, tog = 1'b0;
	int st = 0, pb = 0, eb = 0, lsb = SECT_LSB;
	assign q = r;
	function automatic logic [DW-1:0] rd(input logic [AW-1:0] a);
		return mem.exists(a) ? mem[a] : '1;
	endfunction
	function automatic logic inr(input logic [AW-1:0] a);
		return (a >> lsb) == (ea >> lsb);
	endfunction
	// one latched command cycle; program busy swallows all, erase busy all but suspend
	task automatic cmd(input logic [AW-1:0] a, input logic [DW-1:0] d);
		if (pb > 0) return;
		if (eb > 0 && !susp) begin
			susp = (d == CMD_SUSP);
			return;
		end
		if (susp && st == 0 && d == CMD_RESUME) begin
			susp = 1'b0;
			return;
		end
		case (st)
			0, 3: st = (a == UNL_ADDR1 && d == CMD_UNL1) ? st + 1 : 0;
			1, 4: st = (a == UNL_ADDR2 && d == CMD_UNL2) ? st + 1 : 0;
			2: st = (a != UNL_ADDR1) ? 0 : (d == CMD_PROG) ? 6 : (d == CMD_ERASE) ? 3 : 0;
			5: begin
				st = 0;
				if (eb == 0 && (d == CMD_SECT || d == CMD_BLK)
						&& (protect_n || a[AW-1:BLK_LSB] != PROT_BLK)) begin
					lsb = (d == CMD_SECT) ? SECT_LSB : BLK_LSB;
					ea = a;
					eb = E_CYC;
					foreach (mem[k])
						if (inr(k)) mem[k] = '1;
				end
			end
			default: begin
				st = 0;
				if (!(susp && inr(a))) begin
					pd = d;
					mem[a] = rd(a) & d;
					pb = P_CYC;
				end
			end
		endcase
	endtask
	// pins sampled per clock; idle bus shows inverted last value, never a stale word
	always @(posedge clk_sys) begin
		if (pb > 0) pb = pb - 1;
		if (eb > 0 && !susp) eb = eb - 1;
		if (!we_n && pwe && !ce_n) la = fl_addr;
		if (we_n && !pwe) cmd(la, dq_out);
		if (!oe_n && poe && !ce_n) tog = ~tog;
		w = rd(fl_addr);
		if (pb > 0) w[POLL_POS] = ~pd[POLL_POS];
		if (pb > 0 || (eb > 0 && !susp)) w[TOGGLE_POS] = tog;
		if (pb == 0 && eb > 0 && !susp) w[POLL_POS] = 1'b0;
		if (pb == 0 && eb > 0 && susp && inr(fl_addr)) w[TOGGLE_POS] = 1'b1;
		// outside a suspended region the word is plain array data
		if (pb == 0 && eb > 0 && (!susp || inr(fl_addr))) w[SUSP_TOG_POS] = tog;
		r <= (!ce_n && !oe_n) ? w : ~r;
		pwe = we_n;
		poe = oe_n;
	end
endmodule

/* File: tb/pfci_host_monitor.sv */
// pin and apb timing checks on the flash host controller ports
`timescale 1ns/1ps
module pfci_host_monitor import pfci_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [AW-1:0] fl_addr,
	input wire logic [DW-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic protect_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("late apb answer");
	property p_ready_one;
		pready |=> !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready held too long");
	property p_we_sel;
		!we_n |-> !ce_n;
	endproperty
	a_we_sel: assert property (p_we_sel) else $error("strobe without select");
	property p_pulse;
		$fell(we_n) |-> (!we_n)[*4] ##1 we_n;
	endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse length");
	property p_wr_hold;
		!we_n && $past(!we_n) |-> dq_oe && $stable(fl_addr) && $stable(dq_out);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write moved in pulse");
	property p_dq_hold;
		$rose(we_n) |-> dq_oe && $stable(dq_out);
	endproperty
	a_dq_hold: assert property (p_dq_hold) else $error("data gone at rise");
	property p_no_fight;
		!oe_n |-> !dq_oe && we_n && !ce_n;
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("bus contention");
	property p_rd_len;
		$fell(oe_n) |-> (!oe_n)[*8] ##1 !oe_n ##1 oe_n;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read length");
	property p_prot;
		!ce_n |-> $stable(protect_n);
	endproperty
	a_prot: assert property (p_prot) else $error("protect moved");
endmodule
bind pfci_host pfci_host_monitor pfci_host_monitor_inst (.clk_sys, .rst, .psel, .penable,
	.pready, .ce_n, .we_n, .oe_n, .fl_addr, .dq_out, .dq_oe, .protect_n);

/* File: tb/pfci_host_tb.sv */
// self-checking bench: apb orders to the host, flash model on the pins
`timescale 1ns/1ps
module pfci_host_tb import pfci_pkg::*;;
	localparam logic [AW-1:0] A1 = 22'h012345;
	localparam logic [AW-1:0] A2 = 22'h012b45;
	logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lerr;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic pready, pslverr, ce_n, we_n, oe_n, dq_oe, protect_n;
	logic [AW-1:0] fl_addr;
	logic [DW-1:0] dq_out, fq, dq_in;
	int bad_count = 0, n_tests = 0;
	always #5 clk_sys = ~clk_sys;
	// host owns the data bus while its enable is up, the flash otherwise
	assign dq_in = dq_oe ? dq_out : fq;
	pfci_host #(.ERASE_MAX_CYC(20000)) pfci_host_inst (.clk_sys, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ce_n, .we_n, .oe_n,
		.fl_addr, .dq_out, .dq_oe, .dq_in, .protect_n);
	pfci_flash_model pfci_flash_model_inst (.clk_sys, .ce_n, .we_n, .oe_n, .fl_addr,
		.dq_out, .protect_n, .q(fq));
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until ready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = '0);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		lerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// bounded only by the watchdog
	task automatic wt(input logic [31:0] m, input logic [31:0] v);
		do apb(1'b0, OFS_STATUS); while ((r & m) !== v);
	endtask
	task automatic op(input pfci_op_e c, input logic [AW-1:0] a, input logic [DW-1:0] d,
			input logic w);
		apb(1'b1, OFS_STATUS, 32'h36);
		apb(1'b1, OFS_ADDR, 32'(a));
		apb(1'b1, OFS_WDATA, 32'(d));
		apb(1'b1, OFS_CTRL, 32'(c));
		if (w) wt(32'h1, 32'h0);
	endtask
	task automatic rdw(input logic [AW-1:0] a, input logic [DW-1:0] e);
		op(OP_READ, a, '0, 1'b1);
		apb(1'b0, OFS_RDATA);
		chk(r, 32'(e));
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		apb(1'b0, OFS_CFG);
		chk(r, 32'h1);
		apb(1'b0, OFS_STATUS);
		chk(r, 32'h0);
		chk(32'(protect_n), 32'h1);
		apb(1'b0, 8'h18);
		chk({r[31:1], lerr}, 32'h1);
		// second order while busy is refused; program must end before the poll limit
		op(OP_PROG, A1, 16'h1234, 1'b0);
		apb(1'b1, OFS_CTRL, 32'(OP_PROG));
		wt(32'h1, 32'h0);
		apb(1'b0, OFS_STATUS);
		chk(r & 32'h3f, 32'h12);
		op(OP_PROG, A2, 16'h00ff, 1'b1);
		rdw(A1, 16'h1234);
		op(OP_SECT, A1, '0, 1'b1);
		rdw(A1, 16'hffff);
		rdw(A2, 16'h00ff);
		op(OP_BLK, A1, '0, 1'b1);
		rdw(A2, 16'hffff);
		// bottom block erase refused while the protect pin is low
		apb(1'b1, OFS_CFG, 32'h0);
		op(OP_BLK, 22'h000010, '0, 1'b1);
		apb(1'b0, OFS_STATUS);
		chk(r & 32'h12, 32'h10);
		chk(32'(protect_n), 32'h0);
		apb(1'b1, OFS_CFG, 32'h1);
		// suspend an erase, use the rest of the array, then resume it
		op(OP_PROG, A2, 16'h0f0f, 1'b1);
		op(OP_SECT, A1, '0, 1'b0);
		repeat (200) @(posedge clk_sys);
		apb(1'b1, OFS_CTRL, 32'(OP_SUSP));
		wt(32'ha, 32'ha);
		rdw(A2, 16'h0f0f);
		op(OP_PROG, A1 + 22'h1, 16'h0, 1'b1);
		apb(1'b0, OFS_STATUS);
		chk(r & 32'h10, 32'h10);
		op(OP_PROG, A2 + 22'h1, 16'h5555, 1'b1);
		rdw(A2 + 22'h1, 16'h5555);
		op(OP_RESUME, A1, '0, 1'b1);
		apb(1'b0, OFS_STATUS);
		chk(r & 32'he, 32'h2);
		rdw(A1, 16'hffff);
		tally_and_finish;
	end
	// watchdog: whole sequence needs well under half of this
	initial begin
		repeat (60000) @(posedge clk_sys);
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish;
	end
endmodule
